// ===== hdl/nbu_params.svh
`ifndef NBU_PARAMS_SVH
`define NBU_PARAMS_SVH

// ****************************************************************
// Register byte offsets on the APB bus.
// ****************************************************************
`define NBU_OFF_CTRL 12'h000
`define NBU_OFF_BUF 12'h004
`define NBU_OFF_SLAVE_ADDRESS 12'h008
`define NBU_OFF_SMASK 12'h00c
`define NBU_OFF_BAUD 12'h010

// ****************************************************************
// Control register field positions.
// ****************************************************************
`define NBU_CTRL_MODE_LO 0
`define NBU_CTRL_MODE_HI 1
`define NBU_CTRL_MP 2
`define NBU_CTRL_REN 3
`define NBU_CTRL_TB9 4
`define NBU_CTRL_RB9 5
`define NBU_CTRL_TXF 6
`define NBU_CTRL_RXF 7
`define NBU_CTRL_FAST 8
`define NBU_CTRL_BUSY 9

// ****************************************************************
// Frame modes held in the mode field.
// ****************************************************************
`define NBU_MODE_SHIFT 2'h0
`define NBU_MODE_TEN 2'h1
`define NBU_MODE_NINE_FIX 2'h2
`define NBU_MODE_NINE_VAR 2'h3

// ****************************************************************
// Reset values and bit timing constants.
// ****************************************************************
`define NBU_CTRL_RST 10'h000
`define NBU_ADDR_RST 8'h00
`define NBU_BAUD_RST 16'h0000
`define NBU_CNT_LAST 4'hf
`define NBU_CNT_ZERO 4'h0
`define NBU_SMP_A 4'h6
`define NBU_SMP_B 4'h7
`define NBU_SMP_C 4'h8
`define NBU_RX_PRESET 9'h1ff
`define NBU_END_PATTERN 8'h01

`endif

// ===== hdl/nbu_pkg.sv
`default_nettype none
package nbu_pkg;

  // Transmitter sequencing states.
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_START,
    TX_DATA
  } nbu_tx_e;

  // Receiver sequencing states.
  typedef enum logic [1:0] {
    RX_HUNT,
    RX_FRAME,
    RX_TAIL
  } nbu_rx_e;

  typedef logic [7:0] nbu_byte_t;

  // Given address: compare only where the mask holds one.
  // Broadcast address: OR of address and mask, zeros are don't-care.
  function automatic logic nbu_addr_match(input nbu_byte_t rx, input nbu_byte_t adr,
                                          input nbu_byte_t msk);
    nbu_byte_t bcast;
    bcast = adr | msk;
    nbu_addr_match = (((rx ^ adr) & msk) == 8'h00) || (((rx ^ bcast) & bcast) == 8'h00);
  endfunction

  // Majority of three samples.
  function automatic logic nbu_vote(input logic a, input logic b, input logic c);
    nbu_vote = (a & b) | (a & c) | (b & c);
  endfunction

endpackage
`default_nettype wire

// ===== hdl/nbu_rx_if.sv
`timescale 1ns/1ps
`default_nettype none
// Signals between the register side and the receiver.
interface nbu_rx_if;
  import nbu_pkg::*;
  logic tick;              // Sixteen-times bit rate enable pulse.
  logic enable;            // Receiver may hunt for start bits.
  logic multiproc;         // Multiprocessor filtering on.
  logic addr_chk;          // Nine-bit mode, address recognition applies.
  nbu_byte_t slave_addr;   // Slave address.
  nbu_byte_t slave_mask;   // Slave address mask.
  logic flag_set;          // Receive done flag currently set.
  logic load;              // One-cycle pulse: frame accepted.
  nbu_byte_t data;         // Received data byte.
  logic ninth;             // Received ninth bit.

  modport ctl (output tick, enable, multiproc, addr_chk, slave_addr, slave_mask, flag_set,
               input load, data, ninth);
  modport rx (input tick, enable, multiproc, addr_chk, slave_addr, slave_mask, flag_set,
              output load, data, ninth);
endinterface
`default_nettype wire

// ===== hdl/nbu_rx.sv
`include "nbu_params.svh"
`timescale 1ns/1ps
`default_nettype none
// Receiver: start detection, majority sampling and frame acceptance.
module nbu_rx (
  input wire logic pclk,     // Bus clock.
  input wire logic presetn,  // Asynchronous reset, active low.
  input wire logic rxd,      // Serial input pin.
  nbu_rx_if.rx bus           // Link to the register side.
);
  import nbu_pkg::*;

  // ****************************************************************
  // Pin synchroniser.
  // ****************************************************************
  logic s1_q, s2_q, s3_q;   // Three-stage capture of the pin.
  logic line_q;             // Filtered line level.
  logic line_prev_q;        // Line level at the previous sample tick.

  // The pin passes three flops; only a stable pair updates the line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      line_q <= 1'b1;
    end else begin
      s1_q <= rxd;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        line_q <= s3_q;
      end
    end
  end

  // ****************************************************************
  // Bit sequencing.
  // ****************************************************************
  nbu_rx_e state_q;       // Receiver state.
  logic [3:0] cnt_q;      // Divide-by-16 counter.
  logic [8:0] sr_q;       // Input shift register.
  logic smp_a_q, smp_b_q; // First two samples of the bit.
  logic first_q;          // The bit in progress is the start bit.
  logic bitval;           // Majority value of the current bit.
  logic accept;           // Frame passes the acceptance test.
  nbu_byte_t rx_byte;     // Data bits back in order, first bit at bit 0.

  assign bitval = nbu_vote(smp_a_q, smp_b_q, line_q); // [R10]
  // The first data bit enters at the right and ends at bit 7, so the byte is mirrored.
  assign rx_byte = {sr_q[0], sr_q[1], sr_q[2], sr_q[3], sr_q[4], sr_q[5], sr_q[6], sr_q[7]};
  assign accept = !bus.flag_set &&
                  (!bus.multiproc || (bitval &&
                   (!bus.addr_chk || nbu_addr_match(rx_byte, bus.slave_addr,
                                                    bus.slave_mask)))); // [R13] [R17] [R18]

  // Line sampling happens only on sixteen-times ticks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_prev_q <= 1'b1;
    end else if (bus.tick) begin
      line_prev_q <= line_q; // [R9]
    end
  end

  // Hunt, sample each bit in its middle, finish and rest one bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RX_HUNT;
      cnt_q <= `NBU_CNT_ZERO;
      sr_q <= `NBU_RX_PRESET;
      smp_a_q <= 1'b1;
      smp_b_q <= 1'b1;
      first_q <= 1'b0;
    end else if (!bus.enable) begin
      state_q <= RX_HUNT;
    end else if (bus.tick) begin
      cnt_q <= cnt_q + 4'h1;
      case (state_q)
        RX_HUNT: begin
          // A falling edge restarts the counter and presets the register.
          if (line_prev_q && !line_q) begin
            cnt_q <= `NBU_CNT_ZERO; // [R9]
            sr_q <= `NBU_RX_PRESET; // [R9]
            first_q <= 1'b1;
            state_q <= RX_FRAME;
          end
        end
        RX_FRAME: begin
          // Samples at the seventh and eighth states are held.
          if (cnt_q == `NBU_SMP_A) begin
            smp_a_q <= line_q; // [R10]
          end else if (cnt_q == `NBU_SMP_B) begin
            smp_b_q <= line_q; // [R10]
          end else if (cnt_q == `NBU_SMP_C) begin
            first_q <= 1'b0;
            if (first_q && bitval) begin
              state_q <= RX_HUNT; // [R11]
            end else begin
              sr_q <= {sr_q[7:0], bitval}; // [R12]
              // Start bit at the left end: this is the final shift.
              if (!sr_q[8]) begin
                state_q <= RX_TAIL; // [R12]
              end
            end
          end
        end
        RX_TAIL: begin
          // One full bit time after the final shift, hunt again.
          if (cnt_q == `NBU_SMP_C) begin
            state_q <= RX_HUNT; // [R15]
          end
        end
        default: begin
          state_q <= RX_HUNT;
        end
      endcase
    end
  end

  // Accepted frame results and the load pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.load <= 1'b0;
      bus.data <= 8'h00;
      bus.ninth <= 1'b0;
    end else begin
      bus.load <= 1'b0;
      if (bus.enable && bus.tick && state_q == RX_FRAME && cnt_q == `NBU_SMP_C &&
          !first_q && !sr_q[8] && accept) begin
        bus.load <= 1'b1;      // [R13]
        bus.data <= rx_byte;   // [R14]
        bus.ninth <= bitval;   // [R2] [R14]
      end
    end
  end

endmodule
`default_nettype wire

// ===== hdl/nbu_uart.sv
// Functional notes
// [R1] Frame: start, eight data LSB first, ninth, stop.
// [R2] Send ninth_tx_bit; store received ninth bit.
// [R3] Fixed mode rate: clock over 16 or 32.
// [R4] Variable mode rate from timer overflow.
// [R5] Buffer write loads ninth bit, requests transmit.
// [R6] Transmit starts after next counter rollover.
// [R7] Start bit, then data, then stop inserted.
// [R8] End pattern: last shift, set transmit flag.
// [R9] Falling edge resets counter, presets 1FFH.
// [R10] Majority of samples at states seven-nine.
// [R11] Non-zero start bit aborts reception.
// [R12] Nine-bit register; start leftmost means final.
// [R13] Load only if flag clear and filter passes.
// [R14] Ninth bit and data byte stored on accept.
// [R15] Resume hunting one bit time later.
// [R16] Master sends ninth one for addresses.
// [R17] Shift mode ignores filter; ten-bit checks stop.
// [R18] Filtered frames need ninth one and match.
// [R19] Given match compares only masked bits.
// [R20] Broadcast is address OR mask, zeros ignored.
// [R21] Address and mask reset to zero.
// [R22] Done flags stay set until software clears.
//
// Implementation choices: the placing of the registers and register access over APB.
`include "nbu_params.svh"
`timescale 1ns/1ps
`default_nettype none
// Nine-bit UART with multiprocessor filtering, APB register access.
module nbu_uart (
  input wire logic pclk,            // APB clock, 40 MHz.
  input wire logic presetn,         // Asynchronous reset, active low.
  input wire logic psel,            // APB select.
  input wire logic penable,         // APB access phase.
  input wire logic pwrite,          // APB write direction.
  input wire logic [11:0] paddr,    // APB byte address.
  input wire logic [31:0] pwdata,   // APB write data.
  output logic [31:0] prdata,       // APB read data.
  output logic pready,              // APB ready.
  output logic pslverr,             // APB error on unmapped address.
  input wire logic rxd,             // Serial input pin.
  output logic txd                  // Serial output pin.
);
  import nbu_pkg::*;

  // ****************************************************************
  // Registers and bus handshake.
  // ****************************************************************
  logic [1:0] mode_q;          // Frame mode.
  logic multiproc_enable_q;    // Multiprocessor filter enable.
  logic rx_enable_q;           // Receiver enable.
  logic ninth_tx_bit_q;        // Ninth bit to transmit.
  logic ninth_rx_bit_q;        // Last accepted ninth bit.
  logic tx_done_flag_q;        // Transmit done flag.
  logic rx_done_flag_q;        // Receive done flag.
  logic fast_q;                // Fixed mode divides by 16 instead of 32.
  nbu_byte_t rx_buf_q;         // Received byte, read side of serial_buffer.
  nbu_byte_t slave_address_q;  // Slave address.
  nbu_byte_t slave_addr_mask_q; // Slave address mask.
  logic [15:0] baud_reload_q;  // Timer divisor for the variable mode.

  // Bus answer registers.
  logic pready_q;              // Registered ready.
  logic pslverr_q;             // Registered error.
  logic [31:0] prdata_q;       // Registered read data.

  // Strobes of this transfer.
  logic wr_en;                 // Write completes this edge.
  logic buf_wr;                // Buffer write completes this edge.
  logic ctrl_wr;               // Control write completes this edge.
  logic hit;                   // Address is mapped.
  logic [31:0] rd_val;         // Read multiplexer output.
  logic tx_busy;               // Transmitter is sending or has a request.
  // Link to the receiver.
  nbu_rx_if rif ();            // Receiver link.

  // Read value and address decode.
  always_comb begin
    rd_val = 32'h0000_0000;
    hit = 1'b1;
    // Control word with status.
    if (paddr == `NBU_OFF_CTRL) begin
      rd_val[`NBU_CTRL_MODE_HI:`NBU_CTRL_MODE_LO] = mode_q;
      rd_val[`NBU_CTRL_MP] = multiproc_enable_q;
      rd_val[`NBU_CTRL_REN] = rx_enable_q;
      rd_val[`NBU_CTRL_TB9] = ninth_tx_bit_q;
      rd_val[`NBU_CTRL_RB9] = ninth_rx_bit_q;
      rd_val[`NBU_CTRL_TXF] = tx_done_flag_q;
      rd_val[`NBU_CTRL_RXF] = rx_done_flag_q;
      rd_val[`NBU_CTRL_FAST] = fast_q;
      rd_val[`NBU_CTRL_BUSY] = tx_busy;
    end else if (paddr == `NBU_OFF_BUF) begin
      // Last accepted byte.
      rd_val[7:0] = rx_buf_q;
    end else if (paddr == `NBU_OFF_SLAVE_ADDRESS) begin
      // Address compare value.
      rd_val[7:0] = slave_address_q;
    end else if (paddr == `NBU_OFF_SMASK) begin
      // Don't-care mask.
      rd_val[7:0] = slave_addr_mask_q;
    end else if (paddr == `NBU_OFF_BAUD) begin
      // Tick period reload.
      rd_val[15:0] = baud_reload_q;
    end else begin
      // Unmapped: read zero, error.
      hit = 1'b0;
    end
  end

  // A write lands at the ready edge.
  assign wr_en = psel && penable && pready_q && pwrite && hit;
  assign buf_wr = wr_en && (paddr == `NBU_OFF_BUF);
  assign ctrl_wr = wr_en && (paddr == `NBU_OFF_CTRL);

  // Every access phase waits one cycle, then ready rises for one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle bus: no answer.
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      // Ready follows one wait state.
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !hit;
      // Read data is caught a cycle early.
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= rd_val;
      end
    end
  end

  // Plain configuration registers written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Shift mode: both sides idle.
      mode_q <= `NBU_MODE_SHIFT;
      multiproc_enable_q <= 1'b0;
      rx_enable_q <= 1'b0;
      ninth_tx_bit_q <= 1'b0;
      fast_q <= 1'b0;
      slave_address_q <= `NBU_ADDR_RST;   // [R21]
      slave_addr_mask_q <= `NBU_ADDR_RST; // [R21]
      baud_reload_q <= `NBU_BAUD_RST;
    end else if (wr_en) begin
      if (paddr == `NBU_OFF_CTRL) begin
        // Flags go to their own process.
        mode_q <= pwdata[`NBU_CTRL_MODE_HI:`NBU_CTRL_MODE_LO];
        multiproc_enable_q <= pwdata[`NBU_CTRL_MP];
        rx_enable_q <= pwdata[`NBU_CTRL_REN];
        ninth_tx_bit_q <= pwdata[`NBU_CTRL_TB9];
        fast_q <= pwdata[`NBU_CTRL_FAST];
      end else if (paddr == `NBU_OFF_SLAVE_ADDRESS) begin
        // Zero mask bits ignore these.
        slave_address_q <= pwdata[7:0];
      end else if (paddr == `NBU_OFF_SMASK) begin
        // One bits are compared.
        slave_addr_mask_q <= pwdata[7:0];
      end else if (paddr == `NBU_OFF_BAUD) begin
        // Sets the timer wrap point.
        baud_reload_q <= pwdata[15:0];
      end
    end
  end

  // ****************************************************************
  // Bit rate generation: sixteen-times enable pulse.
  // ****************************************************************
  logic tick_q;           // Sixteen-times sample enable.
  logic half_q;           // Alternates for the divide-by-32 rate.
  logic [15:0] timer_q;   // Timer standing in for the overflow source.


  // Fixed mode ticks every clock or every other clock, variable mode on timer overflow.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // No ticks in reset.
      tick_q <= 1'b0;
      half_q <= 1'b0;
      timer_q <= 16'h0000;
    end else begin
      // Toggles for the slow fixed rate.
      half_q <= !half_q;
      // Wraps after reload plus one.
      if (timer_q >= baud_reload_q) begin
        timer_q <= 16'h0000;
      end else begin
        timer_q <= timer_q + 16'h0001;
      end
      // Fixed mode ignores the timer.
      if (mode_q == `NBU_MODE_NINE_FIX) begin
        tick_q <= fast_q || half_q; // [R3]
      end else begin
        tick_q <= (timer_q >= baud_reload_q); // [R4]
      end
    end
  end

  // ****************************************************************
  // Transmitter.
  // ****************************************************************
  nbu_tx_e tx_state_q;   // Transmit state.
  logic [3:0] tx_cnt_q;  // Transmit divide-by-16 counter.
  logic [8:0] tx_sr_q;   // Transmit shift register.
  logic tx_req_q;        // Pending transmit request.
  logic stop_in_q;       // Stop bit already inside the shift register.
  logic txd_q;           // Serial output.

  logic roll;            // Counter rollover.
  logic tx_end;          // Transmit end pattern reached.

  assign roll = tick_q && (tx_cnt_q == `NBU_CNT_LAST);
  assign tx_busy = tx_req_q || (tx_state_q != TX_IDLE);
  // Ninth bit out, stop beside it.
  assign tx_end = stop_in_q && (tx_sr_q[8:1] == `NBU_END_PATTERN); // [R8]

  // The transmit counter runs freely so bit times follow its rollovers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Counter starts at zero.
      tx_cnt_q <= `NBU_CNT_ZERO;
    end else if (tick_q) begin
      // Advances on sample ticks.
      tx_cnt_q <= tx_cnt_q + 4'h1; // [R6]
    end
  end

  // Sequence start bit, data bits, ninth bit and stop bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= TX_IDLE;
      tx_sr_q <= 9'h000;
      // Line idles high, nothing pending.
      tx_req_q <= 1'b0;
      stop_in_q <= 1'b0;
      txd_q <= 1'b1;
    end else if (buf_wr && !tx_busy && mode_q != `NBU_MODE_SHIFT) begin
      // Busy or shift mode drops writes.
      // Ten-bit mode loads its stop bit directly in the ninth position.
      tx_sr_q <= {(mode_q == `NBU_MODE_TEN) ? 1'b1 : ninth_tx_bit_q, pwdata[7:0]}; // [R5] [R2]
      stop_in_q <= (mode_q == `NBU_MODE_TEN);
      tx_req_q <= 1'b1; // [R5]
    end else if (roll) begin
      case (tx_state_q)
        TX_IDLE: begin
          // A request starts the frame.
          if (tx_req_q) begin
            tx_req_q <= 1'b0;
            txd_q <= 1'b0; // [R6] [R7] [R1]
            tx_state_q <= TX_START;
          end
        end
        TX_START: begin
          // Data bit zero follows.
          txd_q <= tx_sr_q[0]; // [R7]
          tx_state_q <= TX_DATA;
        end
        TX_DATA: begin
          // In nine-bit modes the first shift brings in the stop bit, zeros after it.
          tx_sr_q <= {!stop_in_q, tx_sr_q[8:1]}; // [R7] [R1]
          // Later shifts bring zeros.
          stop_in_q <= 1'b1;
          txd_q <= tx_sr_q[1];
          if (tx_end) begin
            // Stop bit stays on the line.
            txd_q <= 1'b1; // [R8]
            tx_state_q <= TX_IDLE;
          end
        end
        default: begin
          // Stray code returns to idle.
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Done flags and receive buffer.
  // ****************************************************************
  // Hardware only sets; a software write of zero clears, a set in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Both flags start clear.
      tx_done_flag_q <= 1'b0;
      rx_done_flag_q <= 1'b0;
    end else begin
      // Set at the end rollover.
      if (roll && tx_state_q == TX_DATA && tx_end) begin
        tx_done_flag_q <= 1'b1; // [R8] [R22]
      end else if (ctrl_wr && !pwdata[`NBU_CTRL_TXF]) begin
        tx_done_flag_q <= 1'b0; // [R22]
      end
      // Set by the receiver's load.
      if (rif.load) begin
        rx_done_flag_q <= 1'b1; // [R13] [R22]
      end else if (ctrl_wr && !pwdata[`NBU_CTRL_RXF]) begin
        rx_done_flag_q <= 1'b0; // [R22]
      end
    end
  end

  // Accepted frames update the buffer and the ninth bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Buffer starts empty.
      rx_buf_q <= 8'h00;
      ninth_rx_bit_q <= 1'b0;
    end else if (rif.load) begin
      // Both fields change together.
      rx_buf_q <= rif.data;        // [R14]
      ninth_rx_bit_q <= rif.ninth; // [R14] [R2]
    end
  end

  // ****************************************************************
  // Receiver link and instance.
  // ****************************************************************
  // Shared sample tick.
  assign rif.tick = tick_q;
  assign rif.enable = rx_enable_q && (mode_q != `NBU_MODE_SHIFT); // [R17]
  assign rif.multiproc = multiproc_enable_q;
  assign rif.addr_chk = mode_q[1]; // [R18]
  assign rif.slave_addr = slave_address_q;   // [R19]
  assign rif.slave_mask = slave_addr_mask_q; // [R20]
  assign rif.flag_set = rx_done_flag_q;

  // The receiver keeps its own synchroniser.

  nbu_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .rxd(rxd),
    .bus(rif.rx)
  );

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  // Each output is a flop.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign txd = txd_q;

endmodule
`default_nettype wire

// ===== tb/nbu_uart_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the bus handshake and the serial output line.
module nbu_checker (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // Select.
  input wire logic penable, // Access phase.
  input wire logic pwrite, // Direction.
  input wire logic [11:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic rxd, // Serial in.
  input wire logic txd // Serial out.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A setup cycle followed by the first access cycle.
  sequence s_req;
    psel && !penable ##1 psel && penable;
  endsequence
  // A low line level lasts at least eight cycles, half of the fastest bit time.
  sequence s_low;
    (!txd) [*8];
  endsequence
  chk_ready_answer: assert property (s_req |=> pready) else $error("ready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  chk_ready_held: assert property (pready |-> psel && penable) else $error("stray ready");
  chk_err_unmapped: assert property (pready && paddr > 12'h010 |-> pslverr)
    else $error("no error flag");
  chk_err_mapped: assert property (pready && paddr[1:0] == 2'h0 && paddr <= 12'h010
    |-> !pslverr) else $error("false error flag");
  chk_err_rdzero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  chk_start_hold: assert property ($fell(txd) |-> s_low) else $error("short low bit");
  chk_stop_hold: assert property ($rose(txd) |-> txd [*8]) else $error("short high bit");
endmodule
bind nbu_uart nbu_checker u_nbu_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd));
`default_nettype wire

// ===== tb/nbu_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Remote node: sends frames on rxd and decodes frames seen on txd.
module nbu_peer (
  input wire logic pclk, // Clock.
  input wire logic txd, // Line from the block.
  output logic rxd // Line to the block, idle high.
);
  int bitclk = 16; // Clocks per bit time.
  int frames = 0; // Frames decoded.
  logic [10:0] fr = 11'h0; // Last decoded frame, start bit at bit 0.
  initial rxd = 1'b1;
  // Start, eight data bits from the bottom, ninth bit, stop.
  task automatic send(input logic [8:0] v);
    logic [10:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (bitclk) @(posedge pclk);
    end
  endtask
  // A low pulse far shorter than a start bit.
  task automatic glitch();
    rxd <= 1'b0;
    repeat (4) @(posedge pclk);
    rxd <= 1'b1;
    repeat (32) @(posedge pclk);
  endtask
  // Samples every bit of an outgoing frame in its middle.
  always begin
    @(negedge txd);
    repeat (bitclk / 2) @(posedge pclk);
    for (int i = 0; i < 11; i++) begin
      fr = {txd, fr[10:1]};
      if (i < 10) repeat (bitclk) @(posedge pclk);
    end
    frames++;
  end
endmodule
`default_nettype wire

// ===== tb/tb_nine_bit_uart_addr_match.sv
`include "nbu_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_nine_bit_uart_addr_match;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, rxd, txd, err;
  int fail_count = 0;
  int checks = 0;
  int n;
  // Transmit cases: control word, data, clocks per bit.
  logic [9:0] tx_ctl [4] = '{10'h11a, 10'h00a, 10'h01b, 10'h019};
  logic [7:0] tx_dat [4] = '{8'ha5, 8'h3c, 8'h81, 8'h6e};
  int tx_bit [4] = '{16, 32, 48, 48};
  // Filtered receive cases: ninth bit and byte, flag expected.
  logic [8:0] rx_v [5] = '{9'h0c0, 9'h1c2, 9'h1c1, 9'h1ff, 9'h1c0};
  logic rx_hit [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  always #12.5 pclk = ~pclk;
  nbu_uart u_nbu_uart (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd));
  nbu_peer u_nbu_peer (.pclk(pclk), .txd(txd), .rxd(rxd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer; read data and error land in r and err.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge pclk);
    fail_count++;
    results();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `NBU_OFF_SLAVE_ADDRESS, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, `NBU_OFF_SMASK, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk({r[30:0], err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      n = u_nbu_peer.frames;
      u_nbu_peer.bitclk = tx_bit[i];
      apb(1'b1, `NBU_OFF_BAUD, 32'(tx_bit[i] / 16 - 1));
      apb(1'b1, `NBU_OFF_CTRL, {22'h0, tx_ctl[i]});
      apb(1'b1, `NBU_OFF_BUF, {24'h0, tx_dat[i]});
      while (u_nbu_peer.frames == n) @(posedge pclk);
      chk({21'h0, u_nbu_peer.fr}, {21'h0, 1'b1, tx_ctl[i][4], tx_dat[i], 1'b0});
      repeat (tx_bit[i]) @(posedge pclk);
      apb(1'b0, `NBU_OFF_CTRL, 32'h0);
      chk(r & 32'h240, 32'h040);
    end
    u_nbu_peer.bitclk = 16;
    apb(1'b1, `NBU_OFF_CTRL, 32'h10a);
    u_nbu_peer.glitch();
    u_nbu_peer.send(9'h05a);
    u_nbu_peer.send(9'h133);
    repeat (8) @(posedge pclk);
    apb(1'b0, `NBU_OFF_BUF, 32'h0);
    chk(r, 32'h5a);
    apb(1'b0, `NBU_OFF_CTRL, 32'h0);
    chk(r & 32'h0a0, 32'h080);
    apb(1'b1, `NBU_OFF_SLAVE_ADDRESS, 32'hc0);
    apb(1'b1, `NBU_OFF_SMASK, 32'hfd);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `NBU_OFF_CTRL, 32'h10e);
      u_nbu_peer.send(rx_v[i]);
      repeat (8) @(posedge pclk);
      apb(1'b0, `NBU_OFF_CTRL, 32'h0);
      chk({31'h0, r[7]}, {31'h0, rx_hit[i]});
    end
    results();
  end
endmodule
`default_nettype wire
